// *** dacfe_pkg.sv ***
// shared constants and types for the converter front end
package dacfe_pkg;

  // ---------------------------------------------------------------
  // code and segment layout
  // ---------------------------------------------------------------
  localparam int CODE_W = 12;
  localparam int UPPER_HI = 11;
  localparam int UPPER_LO = 7;
  localparam int MID_HI = 6;
  localparam int MID_LO = 3;
  localparam int BIN_HI = 2;
  localparam int UPPER_SRC = 31;
  localparam int MID_SRC = 15;
  localparam int BIN_W = 3;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int CLOCK_HZ = 10_000_000;
  localparam int CLOCK_NS = 1_000_000_000 / CLOCK_HZ;
  localparam int PERIOD_W = 16;
  localparam int LOCK_EDGES = 4;
  localparam logic [PERIOD_W-1:0] PERIOD_TOL = 16'h0001;
  localparam int SYNC_STAGES = 3;

  // ---------------------------------------------------------------
  // register map (byte addresses) and fields
  // ---------------------------------------------------------------
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_CODE = 8'h08;
  localparam logic [7:0] REG_PERIOD = 8'h0c;
  localparam int CTRL_EN_BIT = 0;
  localparam logic CTRL_EN_RESET = 1'b1;
  localparam int ST_LOCK_BIT = 0;
  localparam int ST_MODE_BIT = 1;
  localparam int ST_RANGE_LO = 2;
  localparam int ST_DIVRST_BIT = 4;
  localparam logic [1:0] HTRANS_NONSEQ = 2'b10;
  localparam logic HRESP_OKAY = 1'b0;

  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    RANGE_RANGE_SELECT_HIGH = 2'b00,
    RANGE_DIV2 = 2'b01,
    RANGE_DIV4 = 2'b10,
    RANGE_DIV8 = 2'b11
  } dacfe_range_t;

  typedef struct packed {
    logic [UPPER_SRC-1:0] upper;
    logic [MID_SRC-1:0] middle;
    logic [BIN_W-1:0] binary;
  } dacfe_seg_t;

endpackage

// *** dacfe_sync.sv ***
// three-stage pin synchroniser with agreement filter
`timescale 1ns/1ns
module dacfe_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] pinIn,
  output logic [WIDTH-1:0] levelOut
);

  logic [WIDTH-1:0] s1_q;
  logic [WIDTH-1:0] s2_q;
  logic [WIDTH-1:0] s3_q;
  logic [WIDTH-1:0] level_q;
  logic [WIDTH-1:0] level_d;

  // a bit is accepted only where stages two and three agree
  assign level_d = (s2_q & s3_q) | (level_q & (s2_q | s3_q));
  assign levelOut = level_q;

  // shift chain, first stage read only by the second
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
      level_q <= '0;
    end else begin
      s1_q <= pinIn;
      s2_q <= s1_q;
      s3_q <= s2_q;
      level_q <= level_d;
    end
  end

endmodule

// *** dacfe_seg_decode.sv ***
// segment decoder: thermometer upper and middle, binary lower
`timescale 1ns/1ns
module dacfe_seg_decode
  import dacfe_pkg::*;
(
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [CODE_W-1:0] code,
  output dacfe_seg_t segOut
);

  dacfe_seg_t seg_q;
  dacfe_seg_t seg_d;

  // n ones from the bottom, n at most 31
  function automatic logic [UPPER_SRC-1:0] therm(input logic [4:0] n);
    logic [UPPER_SRC:0] ones;
    ones = ({{UPPER_SRC{1'b0}}, 1'b1} << n) - 32'h1;
    return ones[UPPER_SRC-1:0];
  endfunction

  // ---------------------------------------------------------------
  // decode
  // ---------------------------------------------------------------
  logic [UPPER_SRC-1:0] midWide;
  assign seg_d.upper = therm(code[UPPER_HI:UPPER_LO]);
  assign midWide = therm({1'b0, code[MID_HI:MID_LO]});
  assign seg_d.middle = midWide[MID_SRC-1:0];
  assign seg_d.binary = code[BIN_HI:0];
  assign segOut = seg_q;

  // one register stage keeps the path short for full rate
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      seg_q <= '0;
    end else begin
      seg_q <= seg_d;
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  a_upper_count: assert property (
    ##1 $countones(seg_q.upper) == 32'($past(code[UPPER_HI:UPPER_LO])))
    else $error("upper segment count differs from code");
  a_middle_count: assert property (
    ##1 $countones(seg_q.middle) == 32'($past(code[MID_HI:MID_LO])))
    else $error("middle segment count differs from code");
  a_binary_pass: assert property (
    ##1 seg_q.binary == $past(code[BIN_HI:0]))
    else $error("binary segment not passed through");

endmodule

// *** dacfe_top.sv ***
// converter front end: dual port capture, clock multiplier, segment decode
// Contract
// - top five code bits become a thermometer over 31 unit sources
// - next four bits become a thermometer over 15 sixteenth-weight sources
// - low bits drive binary-weighted sources directly, no thermometer
// - edge-triggered latches and decode sustain full conversion rate
// - multiplier mode is active while the supply strap is high
// - feedback divides by two, giving an internal clock at twice external
// - both ports are captured on the same external clock rising edge
// - lock output comes from the phase detector, high while locked
// - range pins pick prescale 1, 2, 4 or 8
// - range control keeps the oscillator in band down to slow clocks
// - each external rise moves the old second-port word to the output; code does this only in multiplier mode
// - half a period later the first-port word moves to the output
`timescale 1ns/1ns
module dacfe_top
  import dacfe_pkg::*;
(
  input wire logic clock,
  input wire logic rst_n,
  input wire logic extClock,
  input wire logic [CODE_W-1:0] port1Data,
  input wire logic [CODE_W-1:0] port2Data,
  input wire logic multiplierSupplyStrap,
  input wire logic rangeSelectLow,
  input wire logic rangeSelectHigh,
  input wire logic dividerReset,
  output logic loopLockIndicator,
  output dacfe_seg_t segOut,
  output logic sampleStrobe,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp
);

  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  localparam int PIN_W = 2 * CODE_W + 5;
  logic [PIN_W-1:0] pinSync;
  logic extLevel;
  logic [CODE_W-1:0] port1Sync;
  logic [CODE_W-1:0] port2Sync;
  logic modeOn;
  dacfe_range_t rangeSel;
  logic divRstSync;

  dacfe_sync #(.WIDTH(PIN_W)) u_sync (
    .clock(clock),
    .rst_n(rst_n),
    .pinIn({extClock, port1Data, port2Data, multiplierSupplyStrap,
            rangeSelectHigh, rangeSelectLow, dividerReset}),
    .levelOut(pinSync)
  );

  // unpack the filtered levels
  assign extLevel = pinSync[PIN_W-1];
  assign port1Sync = pinSync[PIN_W-2 -: CODE_W];
  assign port2Sync = pinSync[CODE_W+3 : 4];
  assign modeOn = pinSync[3];
  assign rangeSel = dacfe_range_t'(pinSync[2:1]);
  assign divRstSync = pinSync[0];  // status only, never steers the loop

  // prescale ratio for each range setting
  function automatic logic [3:0] prescale(input dacfe_range_t r);
    logic [3:0] n;
    n = 4'h1;
    unique case (r)
      RANGE_RANGE_SELECT_HIGH: n = 4'h1;
      RANGE_DIV2: n = 4'h2;
      RANGE_DIV4: n = 4'h4;
      RANGE_DIV8: n = 4'h8;
    endcase
    return n;
  endfunction

  // ---------------------------------------------------------------
  // register state
  // ---------------------------------------------------------------
  logic extLevel_q;
  logic [CODE_W-1:0] p1Latch_q;
  logic [CODE_W-1:0] p2Latch_q;
  logic [CODE_W-1:0] outCode_q;
  logic [CODE_W-1:0] outCode_d;
  logic [PERIOD_W-1:0] sinceRise_q;
  logic [PERIOD_W-1:0] period_q;
  logic [PERIOD_W-1:0] refPeriod_q;
  logic periodValid_q;
  logic [3:0] refCnt_q;
  logic [3:0] fbCnt_q;
  logic [2:0] lockCnt_q;
  logic lock_q;
  logic strobe_q;
  logic convEnable_q;

  // ---------------------------------------------------------------
  // edge and tick decode
  // ---------------------------------------------------------------
  logic extRise;
  logic [PERIOD_W-1:0] halfPeriod;
  logic halfTick;
  logic intTick;
  logic [3:0] ratio;
  logic refEdge;
  logic [PERIOD_W-1:0] newPeriod;
  logic [PERIOD_W-1:0] periodDiff;
  logic periodStable;
  logic phaseOk;
  logic [3:0] fbTarget;

  assign extRise = extLevel && !extLevel_q;
  assign halfPeriod = period_q >> 1;
  // half-period tick from the measured period, so duty cycle does not matter
  assign halfTick = modeOn && periodValid_q && !extRise && (halfPeriod != '0)
                    && (sinceRise_q == halfPeriod - 16'h0001);
  // internal double-rate clock: one tick per rise, one per half period
  assign intTick = (modeOn && extRise) || halfTick;
  assign ratio = prescale(rangeSel);
  assign refEdge = modeOn && extRise && (refCnt_q == ratio - 4'h1);
  assign newPeriod = sinceRise_q + 16'h0001;
  assign periodDiff = (period_q > refPeriod_q) ? period_q - refPeriod_q
                                               : refPeriod_q - period_q;
  assign periodStable = periodValid_q && (periodDiff <= PERIOD_TOL);
  // feedback divides by two then by the prescaler: 2n-1 ticks between edges
  assign fbTarget = 4'((ratio << 1) - 4'h1);
  assign phaseOk = (fbCnt_q == fbTarget);

  // output latch source: old port 2 on the rise, port 1 at the half
  always_comb begin
    outCode_d = outCode_q;
    if (modeOn && convEnable_q && extRise) begin
      outCode_d = p2Latch_q;
    end else if (convEnable_q && halfTick) begin
      outCode_d = p1Latch_q;
    end
  end

  // ---------------------------------------------------------------
  // capture, output latch and period measurement
  // ---------------------------------------------------------------
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      extLevel_q <= 1'b0;
      p1Latch_q <= '0;
      p2Latch_q <= '0;
      outCode_q <= '0;
      strobe_q <= 1'b0;
    end else begin
      extLevel_q <= extLevel;
      outCode_q <= outCode_d;
      strobe_q <= (outCode_d != outCode_q) || (convEnable_q && intTick);
      if (modeOn && extRise) begin
        p1Latch_q <= port1Sync;
        p2Latch_q <= port2Sync;
      end
    end
  end

  // cycles between rises, saturating
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      sinceRise_q <= '0;
      period_q <= '0;
      periodValid_q <= 1'b0;
    end else if (extRise) begin
      sinceRise_q <= '0;
      period_q <= newPeriod;
      periodValid_q <= modeOn && extLevel_q == 1'b0 && (sinceRise_q != '1);
    end else if (sinceRise_q != '1) begin
      sinceRise_q <= newPeriod;
    end
  end

  // ---------------------------------------------------------------
  // prescaler, feedback divider and phase detector
  // ---------------------------------------------------------------
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      refCnt_q <= '0;
      fbCnt_q <= '0;
      refPeriod_q <= '0;
      lockCnt_q <= '0;
      lock_q <= 1'b0;
    end else if (!modeOn) begin
      refCnt_q <= '0;
      fbCnt_q <= '0;
      lockCnt_q <= '0;
      lock_q <= 1'b0;
    end else if (refEdge) begin
      refCnt_q <= '0;
      fbCnt_q <= '0;
      refPeriod_q <= period_q;
      if (periodStable && phaseOk) begin
        if (lockCnt_q != 3'(LOCK_EDGES)) begin
          lockCnt_q <= lockCnt_q + 3'h1;
        end
        lock_q <= (lockCnt_q >= 3'(LOCK_EDGES - 1));
      end else begin
        lockCnt_q <= '0;
        lock_q <= 1'b0;
      end
    end else begin
      if (extRise) begin
        refCnt_q <= refCnt_q + 4'h1;
      end
      if (intTick && fbCnt_q != 4'hf) begin
        fbCnt_q <= fbCnt_q + 4'h1;
      end
    end
  end

  // ---------------------------------------------------------------
  // segment decode
  // ---------------------------------------------------------------
  dacfe_seg_decode u_decode (
    .clock(clock),
    .rst_n(rst_n),
    .code(outCode_q),
    .segOut(segOut)
  );

  assign loopLockIndicator = lock_q;
  assign sampleStrobe = strobe_q;

  // ---------------------------------------------------------------
  // AHB-Lite slave, zero wait states
  // ---------------------------------------------------------------
  logic addrTake;
  logic wrPend_q;
  logic [7:0] wrAddr_q;
  logic [31:0] rdData_q;
  logic [31:0] rdData_d;
  logic [7:0] offs;

  assign addrTake = hsel && hready && (htrans == HTRANS_NONSEQ);
  assign offs = haddr[7:0];
  assign hreadyout = 1'b1;
  assign hresp = HRESP_OKAY;
  assign hrdata = rdData_q;

  // read mux, unmapped offsets read zero
  always_comb begin
    rdData_d = '0;
    if (addrTake && !hwrite && haddr[31:8] == '0) begin
      unique case (offs)
        REG_CTRL: rdData_d[CTRL_EN_BIT] = convEnable_q;
        REG_STATUS: begin
          rdData_d[ST_LOCK_BIT] = lock_q;
          rdData_d[ST_MODE_BIT] = modeOn;
          rdData_d[ST_RANGE_LO +: 2] = rangeSel;
          rdData_d[ST_DIVRST_BIT] = divRstSync;
        end
        REG_CODE: rdData_d[CODE_W-1:0] = outCode_q;
        REG_PERIOD: rdData_d[PERIOD_W-1:0] = period_q;
        default: rdData_d = '0;
      endcase
    end
  end

  // address phase capture and write in the data phase
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      wrPend_q <= 1'b0;
      wrAddr_q <= '0;
      rdData_q <= '0;
      convEnable_q <= CTRL_EN_RESET;
    end else begin
      wrPend_q <= addrTake && hwrite && (haddr[31:8] == '0);
      wrAddr_q <= offs;
      rdData_q <= rdData_d;
      if (wrPend_q && wrAddr_q == REG_CTRL) begin
        convEnable_q <= hwdata[CTRL_EN_BIT];
      end
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  sequence s_rise_taken;
    modeOn && extRise;
  endsequence

  a_both_ports: assert property (
    s_rise_taken |=> p1Latch_q == $past(port1Sync) && p2Latch_q == $past(port2Sync))
    else $error("ports not captured on the same rise");
  a_rise_output: assert property (
    s_rise_taken and convEnable_q |=> outCode_q == $past(p2Latch_q))
    else $error("output did not take old second port word");
  a_half_output: assert property (
    halfTick && convEnable_q |=> outCode_q == $past(p1Latch_q) ##0 !halfTick)
    else $error("output did not take first port word at half");
  a_half_place: assert property (
    halfTick |-> 17'(sinceRise_q) + 17'h1 == 17'(period_q >> 1))
    else $error("half tick not at half the period");
  a_lock_off: assert property (!modeOn |=> !lock_q)
    else $error("lock shown outside multiplier mode");
  a_lock_rise: assert property (
    $rose(lock_q) |-> $past(refEdge) && $past(lockCnt_q) >= 3'(LOCK_EDGES - 1))
    else $error("lock rose without enough good edges");
  a_lock_drop: assert property (
    refEdge && !(periodStable && phaseOk) |=> !loopLockIndicator)
    else $error("lock kept after a bad phase compare");
  a_ref_ratio: assert property (
    refEdge |-> refCnt_q == ratio - 4'h1 && ratio == (4'h1 << rangeSel))
    else $error("prescaler edge at wrong count");

endmodule

// *** dacfe_source.sv ***
// sample source model: drives the clock pin and both data ports
`timescale 1ns/1ns
module dacfe_source
  import dacfe_pkg::*;
(
  input wire logic clock,
  input wire logic rst_n,
  input wire logic run,
  output logic extClock,
  output logic [CODE_W-1:0] port1Data,
  output logic [CODE_W-1:0] port2Data,
  output logic dividerReset
);
  // ---------------------------------------------------------------
  // uneven duty cycle, rate far above the slow-rate floor
  // ---------------------------------------------------------------
  localparam int HIGH_CYC = 5;
  localparam int LOW_CYC = 11;
  logic [7:0] cnt;
  logic [CODE_W-1:0] idx;
  logic [CODE_W-1:0] nextIdx;
  assign nextIdx = idx + 12'h001;
  // divider reset held grounded in multiplier mode
  assign dividerReset = 1'b0;
  // clock stands low when idle; words change only on the fall
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      extClock <= 1'b0;
      cnt <= 8'h00;
      idx <= 12'h000;
      port1Data <= 12'h000;
      port2Data <= 12'hfff;
    end else if (!run) begin
      extClock <= 1'b0;
      cnt <= 8'h00;
    end else if (int'(cnt) == (extClock ? HIGH_CYC : LOW_CYC) - 1) begin
      cnt <= 8'h00;
      extClock <= !extClock;
      if (extClock) begin
        idx <= nextIdx;
        port1Data <= nextIdx * 12'h025;
        port2Data <= 12'hfff - nextIdx * 12'h035;
      end
    end else begin
      cnt <= cnt + 8'h01;
    end
  end
endmodule

// *** tb_top.sv ***
// self-checking bench for the converter front end
`timescale 1ns/1ns
module tb_top
  import dacfe_pkg::*;
;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic run = 1'b0;
  logic strap = 1'b0;
  logic rngLo = 1'b0;
  logic rngHi = 1'b0;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [1:0] htrans = 2'b00;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic extClock, divRst, lockInd, strobe, hreadyout, hresp, recOn;
  logic [CODE_W-1:0] p1, p2;
  logic [31:0] hrdata;
  dacfe_seg_t segOut, lastSeg;
  logic [12:0] codeQ[$];
  int timeQ[$];
  int mismatches = 0;
  int comparisons = 0;
  int cyc = 0;
  int strobes = 0;

  dacfe_source src (.clock(clock), .rst_n(rst_n), .run(run), .extClock(extClock),
    .port1Data(p1), .port2Data(p2), .dividerReset(divRst));
  dacfe_top dut (.clock(clock), .rst_n(rst_n), .extClock(extClock), .port1Data(p1),
    .port2Data(p2), .multiplierSupplyStrap(strap), .rangeSelectLow(rngLo),
    .rangeSelectHigh(rngHi), .dividerReset(divRst), .loopLockIndicator(lockInd),
    .segOut(segOut), .sampleStrobe(strobe), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp));

  always #50 clock = ~clock;

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  // weight the segments back into a code; top bit flags a broken thermometer
  function automatic logic [12:0] segCode(dacfe_seg_t s);
    logic [11:0] c;
    logic bad;
    c = {9'h000, s.binary};
    bad = ((s.upper & (s.upper + 31'h1)) != 0) || ((s.middle & (s.middle + 15'h1)) != 0);
    for (int i = 0; i < UPPER_SRC; i++) c = c + (s.upper[i] ? 12'h080 : 12'h000);
    for (int i = 0; i < MID_SRC; i++) c = c + (s.middle[i] ? 12'h008 : 12'h000);
    return {bad, c};
  endfunction

  // output order: even step old port 2 word, odd step port 1 word
  function automatic logic [11:0] seqWord(int j);
    logic [11:0] k;
    k = 12'(j / 2);
    return (j % 2 == 1) ? k * 12'h025 : 12'hfff - (k - 12'h001) * 12'h035;
  endfunction

  // record every segment update with its cycle
  always @(posedge clock) begin
    cyc++;
    if (recOn === 1'b1 && segOut !== lastSeg) begin
      codeQ.push_back(segCode(segOut));
      timeQ.push_back(cyc);
    end
    if (recOn === 1'b1 && strobe === 1'b1) strobes++;
    lastSeg <= segOut;
  end

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  // one single-word transfer: address phase, then data phase
  task automatic xfer(input logic [31:0] a, input logic w, input logic [31:0] wd,
                      output logic [31:0] rd);
    int n;
    logic late;
    n = 0;
    late = 1'b0;
    @(posedge clock);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= HTRANS_NONSEQ;
    do begin @(posedge clock); n++; end while (hreadyout !== 1'b1 && n < 20);
    late = (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    do begin @(posedge clock); n++; end while (hreadyout !== 1'b1 && n < 40);
    rd = hrdata;
    check("response", {31'h0, HRESP_OKAY}, {31'h0, hresp});
    if (late || hreadyout !== 1'b1) begin
      mismatches++;
      conclude();
    end
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] x;
    xfer(a, 1'b1, d, x);
  endtask

  task automatic rdChk(input string what, input logic [31:0] a, input logic [31:0] exp);
    logic [31:0] x;
    xfer(a, 1'b0, 32'h0, x);
    check(what, exp, x);
  endtask

  task automatic waitLock();
    int n;
    n = 0;
    while (lockInd !== 1'b1 && n < 4000) begin @(posedge clock); n++; end
    if (n >= 4000) begin
      mismatches++;
      conclude();
    end
  endtask

  task automatic record(input int n);
    codeQ.delete();
    timeQ.delete();
    strobes = 0;
    recOn <= 1'b1;
    repeat (n) @(posedge clock);
    recOn <= 1'b0;
    @(posedge clock);
  endtask

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic regsAfterReset();
    rdChk("ctrl reset", REG_CTRL, 32'h1);
    rdChk("status idle", REG_STATUS, 32'h0);
    rdChk("unmapped", 32'h10, 32'h0);
    rdChk("high address", 32'h108, 32'h0);
    wr(REG_STATUS, 32'hffffffff);
    rdChk("status read only", REG_STATUS, 32'h0);
  endtask

  task automatic lockRanges();
    strap <= 1'b1;
    run <= 1'b1;
    for (int r = 0; r < 4; r++) begin
      {rngHi, rngLo} <= 2'(r);
      repeat (100) @(posedge clock);
      waitLock();
      rdChk("status locked", REG_STATUS, 32'h3 | (r << 2));
    end
    rdChk("period", REG_PERIOD, 32'd16);
  endtask

  task automatic dataOrder();
    int start;
    start = -1;
    record(200);
    check("updates seen", 32'h1, {31'h0, codeQ.size() >= 20});
    check("strobes seen", 32'h1, {31'h0, strobes > 0 && strobes + 1 >= codeQ.size()
          && strobes <= codeQ.size() + 1});
    for (int j = 2; j < 8192; j++)
      if (start < 0 && seqWord(j) == codeQ[0][11:0] && seqWord(j + 1) == codeQ[1][11:0])
        start = j;
    check("order found", 32'h1, {31'h0, start >= 0});
    if (start < 0) start = 0;
    for (int i = 0; i < codeQ.size(); i++)
      check("segments", {20'h0, seqWord(start + i)},
            {19'h0, codeQ[i]});
    for (int i = 1; i < timeQ.size(); i++)
      check("spacing", 32'd8, timeQ[i] - timeQ[i - 1]);
  endtask

  task automatic freeze();
    logic [31:0] c0, c1;
    wr(REG_CTRL, 32'h0);
    repeat (4) @(posedge clock);
    xfer(REG_CODE, 1'b0, 32'h0, c0);
    record(100);
    xfer(REG_CODE, 1'b0, 32'h0, c1);
    check("frozen updates", 32'h0, codeQ.size());
    check("frozen strobes", 32'h0, strobes);
    check("frozen code", c0, c1);
    wr(REG_CTRL, 32'h1);
    rdChk("ctrl back", REG_CTRL, 32'h1);
    record(60);
    check("resumed", 32'h1, {31'h0, codeQ.size() > 0});
  endtask

  task automatic strapOff();
    strap <= 1'b0;
    repeat (40) @(posedge clock);
    check("lock off", 32'h0, {31'h0, lockInd});
    rdChk("status off", REG_STATUS, 32'hc);
    record(100);
    check("no updates off", 32'h0, codeQ.size());
    check("no strobes off", 32'h0, strobes);
    strap <= 1'b1;
    waitLock();
    check("lock again", 32'h1, {31'h0, lockInd});
  endtask

  initial begin
    recOn = 1'b0;
    repeat (8) @(posedge clock);
    rst_n <= 1'b1;
    regsAfterReset();
    lockRanges();
    dataOrder();
    freeze();
    strapOff();
    conclude();
  end

  // cut a hang short
  initial begin
    #(100 * 60000);
    mismatches++;
    conclude();
  end
endmodule
